// File: core/spc_path.sv
`timescale 1ns/1ns
`include "spc_map.svh"
// Function
// - Transmit select LOW: transmit interface uses reference.
// - Receive select LOW, decoder on: elastic buffer.
// - Elastic buffer adds or drops framing characters.
// - Add: framing character follows a framing character.
// - Drop: discard framing character where detected.
// - Reset clears state, sets both buffer pointers to entry zero.
// - Outputs settle fewer than sixteen cycles after reset.
// - Reset clears output and power latches, sets both selftest bits.
// - Input select HIGH primary, LOW secondary.
// - Loopback feeds transmit stream, ignores serial inputs.
// - Loopback holds enabled drivers at logic one.
// - Strobe HIGH: enable latch is transparent.
// - Strobe falling: enable latch holds last values.
// - Reset disables both serial drivers.
// - Receive select MID: bypass buffer, recovered clock.
module spc_path #(
   parameter int FIFO_DEPTH = 8,
   parameter int HIGH_MARK  = 6,
   parameter int LOW_MARK   = 2
) (
   input  wire logic                core_clk,
   input  wire logic                resetn,
   // Static selects from the host.
   input  wire logic                tx_clock_select,
   input  wire spc_pkg::spc_level_t rx_clock_select,
   input  wire spc_pkg::spc_level_t decoder_mode_select,
   // Asynchronous control pins.
   input  wire logic                serial_input_select,
   input  wire logic                loopback_enable,
   input  wire logic                out_enable_latch_strobe,
   input  wire logic                selftest_latch_strobe,
   input  wire logic                rx_power_latch_strobe,
   input  wire logic [1:0]          enable_lines,
   // Serial side.
   input  wire logic                primary_serial_in,
   input  wire logic                secondary_serial_in,
   input  wire logic                tx_serial_bit,
   output logic                     cdr_serial_bit,
   output logic                     primary_serial_out,
   output logic                     secondary_serial_out,
   output logic [1:0]               driver_enable,
   // Clock routing status.
   output logic                     tx_clock_from_ref,
   output logic                     rx_clock_from_ref,
   output logic                     elastic_active,
   // Configuration latch contents.
   output logic [1:0]               selftest_enable,
   output logic                     rx_power_enable,
   // Received characters from the decoder.
   input  wire logic                rx_char_valid,
   output logic                     rx_char_ready,
   input  wire logic [7:0]          rx_char_data,
   input  wire logic                rx_char_special,
   // Characters toward the parallel receive interface.
   output logic                     rx_out_valid,
   input  wire logic                rx_out_ready,
   output logic [7:0]               rx_out_data,
   output logic                     rx_out_special,
   output logic                     rx_char_added,
   output logic                     rx_char_dropped,
   output logic                     rx_path_settled
);
   localparam int CW = $clog2(FIFO_DEPTH+1);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers.
   ////////////////////////////////////////////////////////////////////////////
   logic [`SPC_PIN_W-1:0] pin_meta;
   logic [`SPC_PIN_W-1:0] pin_sync;
   logic [`SPC_PIN_W-1:0] pin_raw;

   assign pin_raw = {secondary_serial_in, primary_serial_in, enable_lines,
                     rx_power_latch_strobe, selftest_latch_strobe,
                     out_enable_latch_strobe, serial_input_select, loopback_enable};

   // Every pin is asynchronous, so each passes two flops; only stage two is read.
   always_ff @(posedge core_clk) begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
   end

   logic       loop_on;
   logic [1:0] en_lines;
   assign loop_on  = pin_sync[`SPC_PIN_LOOP];
   assign en_lines = {pin_sync[`SPC_PIN_EN_HI], pin_sync[`SPC_PIN_EN_LO]};

   ////////////////////////////////////////////////////////////////////////////
   // Configuration latches.
   ////////////////////////////////////////////////////////////////////////////
   logic [1:0] oe_latch, next_oe_latch;
   logic [1:0] st_latch, next_st_latch;
   logic       rxp_latch, next_rxp_latch;

   // A latch follows the lines while its strobe is high and keeps the last
   // sampled value once the strobe drops, since the strobe is held off it.
   always_comb begin
      next_oe_latch  = oe_latch;
      next_st_latch  = st_latch;
      next_rxp_latch = rxp_latch;
      if (pin_sync[`SPC_PIN_OE_STB]) begin
         next_oe_latch = en_lines;
      end
      if (pin_sync[`SPC_PIN_ST_STB]) begin
         next_st_latch = en_lines;
      end
      if (pin_sync[`SPC_PIN_RXP_STB]) begin
         next_rxp_latch = en_lines[0];
      end
   end

   // Reset clears the output enable and power latches and sets both selftest bits.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         oe_latch  <= `SPC_OE_RST;
         st_latch  <= `SPC_SELFTEST_RST;
         rxp_latch <= `SPC_RXPWR_RST;
      end else begin
         oe_latch  <= next_oe_latch;
         st_latch  <= next_st_latch;
         rxp_latch <= next_rxp_latch;
      end
   end

   assign driver_enable   = oe_latch;
   assign selftest_enable = st_latch;
   assign rx_power_enable = rxp_latch;

   ////////////////////////////////////////////////////////////////////////////
   // Serial routing and drivers.
   ////////////////////////////////////////////////////////////////////////////
   logic       next_cdr_bit;
   logic [1:0] drv_out, next_drv_out;

   // Loopback takes priority over the input selector so that a stray input
   // select change cannot leak external data into the recovery path.
   always_comb begin
      if (loop_on) begin
         next_cdr_bit = tx_serial_bit;
      end else if (pin_sync[`SPC_PIN_SERIAL_INPUT_SELECT]) begin
         next_cdr_bit = pin_sync[`SPC_PIN_PRI_IN];
      end else begin
         next_cdr_bit = pin_sync[`SPC_PIN_SEC_IN];
      end
   end

   // One driver per enable bit; a disabled driver idles low, powered down.
   for (genvar d = 0; d < 2; d++) begin : g_drv
      always_comb begin
         if (!oe_latch[d]) begin
            next_drv_out[d] = 1'b0;
         end else if (loop_on) begin
            next_drv_out[d] = 1'b1;
         end else begin
            next_drv_out[d] = tx_serial_bit;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         cdr_serial_bit <= 1'b0;
         drv_out        <= 2'h0;
      end else begin
         cdr_serial_bit <= next_cdr_bit;
         drv_out        <= next_drv_out;
      end
   end

   assign primary_serial_out   = drv_out[0];
   assign secondary_serial_out = drv_out[1];

   ////////////////////////////////////////////////////////////////////////////
   // Clock routing and settle counter.
   ////////////////////////////////////////////////////////////////////////////
   logic       elastic;
   logic [3:0] settle_cnt, next_settle_cnt;
   logic       settled;

   // A HIGH receive select is invalid and is treated like the bypass setting.
   assign elastic = (rx_clock_select == spc_pkg::SPC_LVL_LOW) &&
                    (decoder_mode_select != spc_pkg::SPC_LVL_LOW);
   assign tx_clock_from_ref = ~tx_clock_select;
   assign rx_clock_from_ref = elastic;
   assign elastic_active    = elastic;

   // The count saturates well below sixteen, bounding the time to settle.
   always_comb begin
      next_settle_cnt = settle_cnt;
      if (!settled) begin
         next_settle_cnt = settle_cnt + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         settle_cnt <= 4'h0;
      end else begin
         settle_cnt <= next_settle_cnt;
      end
   end

   assign settled         = (settle_cnt == `SPC_SETTLE_CYCLES);
   assign rx_path_settled = settled;

   ////////////////////////////////////////////////////////////////////////////
   // Elasticity buffer write side.
   ////////////////////////////////////////////////////////////////////////////
   logic          in_frame;
   logic          drop;
   logic          fifo_in_ready;
   logic          fifo_out_valid;
   logic          fifo_pop;
   logic [8:0]    fifo_out;
   logic [CW-1:0] fifo_level;

   assign in_frame = rx_char_special && (rx_char_data == `SPC_FRAME_CHAR);

   // Near overflow a framing character is consumed without being stored.
   assign drop = elastic && settled && rx_char_valid && in_frame &&
                 (fifo_level >= CW'(HIGH_MARK));
   assign rx_char_ready = drop | (fifo_in_ready & settled);

   spc_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .core_clk  (core_clk),
      .resetn    (resetn),
      .in_valid  (rx_char_valid & ~drop & settled),
      .in_ready  (fifo_in_ready),
      .in_data   ({rx_char_special, rx_char_data}),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_pop),
      .out_data  (fifo_out),
      .level     (fifo_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Elasticity buffer read side.
   ////////////////////////////////////////////////////////////////////////////
   spc_pkg::spc_rd_state_t rd_state, next_rd_state;
   logic                   ins_pend, next_ins_pend;
   logic                   out_v, next_out_v;
   logic [7:0]             out_d, next_out_d;
   logic                   out_k, next_out_k;
   logic                   added, next_added;
   logic                   slot_free;
   logic                   head_frame;

   assign slot_free  = ~out_v | rx_out_ready;
   assign head_frame = fifo_out[8] && (fifo_out[7:0] == `SPC_FRAME_CHAR);

   // In elastic mode reading waits until the buffer reaches half depth, so
   // the write and read pointers start at their nominal distance apart.
   always_comb begin
      next_rd_state = rd_state;
      next_ins_pend = ins_pend;
      next_out_v    = out_v & ~rx_out_ready;
      next_out_d    = out_d;
      next_out_k    = out_k;
      next_added    = 1'b0;
      fifo_pop      = 1'b0;
      unique case (rd_state)
         spc_pkg::SPC_RD_FILL: begin
            if (!elastic || fifo_level >= CW'(FIFO_DEPTH/2)) begin
               next_rd_state = spc_pkg::SPC_RD_RUN;
            end
         end
         spc_pkg::SPC_RD_RUN: begin
            if (slot_free && elastic && ins_pend) begin
               next_out_v    = 1'b1;
               next_out_d    = `SPC_FRAME_CHAR;
               next_out_k    = 1'b1;
               next_ins_pend = 1'b0;
               next_added    = 1'b1;
            end else if (slot_free && fifo_out_valid) begin
               fifo_pop   = 1'b1;
               next_out_v = 1'b1;
               next_out_d = fifo_out[7:0];
               next_out_k = fifo_out[8];
               // Near underrun a copy is queued behind the framing character.
               if (elastic && head_frame && fifo_level <= CW'(LOW_MARK)) begin
                  next_ins_pend = 1'b1;
               end
            end else if (elastic && !fifo_out_valid && !ins_pend) begin
               next_rd_state = spc_pkg::SPC_RD_FILL;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         rd_state <= spc_pkg::SPC_RD_FILL;
         ins_pend <= 1'b0;
         out_v    <= 1'b0;
         out_d    <= 8'h00;
         out_k    <= 1'b0;
         added    <= 1'b0;
      end else begin
         rd_state <= next_rd_state;
         ins_pend <= next_ins_pend;
         out_v    <= next_out_v;
         out_d    <= next_out_d;
         out_k    <= next_out_k;
         added    <= next_added;
      end
   end

   // Drop flag is registered so that rx_char_dropped, like rx_char_added, comes from a flop.
   logic dropped;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         dropped <= 1'b0;
      end else begin
         dropped <= drop;
      end
   end

   assign rx_out_valid    = out_v;
   assign rx_out_data     = out_d;
   assign rx_out_special  = out_k;
   assign rx_char_added   = added;
   assign rx_char_dropped = dropped;
endmodule

// File: pkg/spc_map.svh
`ifndef SPC_MAP_SVH
`define SPC_MAP_SVH
// Framing character as delivered by the decoder: data byte plus special flag.
`define SPC_FRAME_CHAR      8'hBC
// Reset values of the three configuration latches.
`define SPC_OE_RST          2'h0
`define SPC_SELFTEST_RST    2'h3
`define SPC_RXPWR_RST       1'h0
// Cycles after reset release before the receive path is declared settled.
`define SPC_SETTLE_CYCLES   4'hC
// Positions inside the synchronised pin vector.
`define SPC_PIN_LOOP        0
`define SPC_PIN_SERIAL_INPUT_SELECT       1
`define SPC_PIN_OE_STB      2
`define SPC_PIN_ST_STB      3
`define SPC_PIN_RXP_STB     4
`define SPC_PIN_EN_LO       5
`define SPC_PIN_EN_HI       6
`define SPC_PIN_PRI_IN      7
`define SPC_PIN_SEC_IN      8
`define SPC_PIN_W           9
`endif

// File: pkg/spc_pkg.sv
package spc_pkg;
   // Three-level static select pin.
   typedef enum logic [1:0] {SPC_LVL_LOW, SPC_LVL_MID, SPC_LVL_HIGH} spc_level_t;
   // Elasticity buffer read side.
   typedef enum logic [0:0] {SPC_RD_FILL, SPC_RD_RUN} spc_rd_state_t;
endpackage

// File: core/spc_fifo.sv
`timescale 1ns/1ns
module spc_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   input  wire logic                       core_clk,
   input  wire logic                       resetn,
   input  wire logic                       in_valid,
   output logic                            in_ready,
   input  wire logic [WIDTH-1:0]           in_data,
   output logic                            out_valid,
   input  wire logic                       out_ready,
   output logic [WIDTH-1:0]                out_data,
   output logic [$clog2(DEPTH+1)-1:0]      level
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH+1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [CW-1:0]    next_level;
   logic             push, pop;

   // Full and empty come straight from the fill count, so they never lie.
   assign in_ready  = (level != CW'(DEPTH));
   assign out_valid = (level != '0);
   assign out_data  = mem[rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointer and count update; pointers wrap at DEPTH.
   always_comb begin
      next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
      next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
      next_level  = level + CW'(push) - CW'(pop);
   end

   // Reset empties the buffer and sets both pointers to entry zero.
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         level  <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         level  <= next_level;
      end
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// File: tb/spc_path_monitor.sv
`timescale 1ns/1ns
// Timing checks on the serial path control block; sees only its ports.
module spc_path_monitor (
   input wire logic                core_clk,
   input wire logic                resetn,
   input wire logic                tx_clock_select,
   input wire spc_pkg::spc_level_t rx_clock_select,
   input wire spc_pkg::spc_level_t decoder_mode_select,
   input wire logic                serial_input_select,
   input wire logic                loopback_enable,
   input wire logic                out_enable_latch_strobe,
   input wire logic [1:0]          enable_lines,
   input wire logic                primary_serial_in,
   input wire logic                tx_serial_bit,
   input wire logic                cdr_serial_bit,
   input wire logic                primary_serial_out,
   input wire logic                secondary_serial_out,
   input wire logic [1:0]          driver_enable,
   input wire logic                tx_clock_from_ref,
   input wire logic                rx_clock_from_ref,
   input wire logic                elastic_active,
   input wire logic [1:0]          selftest_enable,
   input wire logic                rx_power_enable,
   input wire logic                rx_char_valid,
   input wire logic                rx_char_ready,
   input wire logic [7:0]          rx_char_data,
   input wire logic                rx_char_special,
   input wire logic                rx_out_valid,
   input wire logic [7:0]          rx_out_data,
   input wire logic                rx_out_special,
   input wire logic                rx_char_added,
   input wire logic                rx_char_dropped,
   input wire logic                rx_path_settled
);
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   logic [3:0] hi_cnt;
   logic [3:0] next_hi_cnt;
   logic       frame_take;
   ////////////////////////////////////////////////////////////////////////////////
   // Edges since reset release, saturating so a long run cannot wrap it.
   always_comb begin
      next_hi_cnt = hi_cnt;
      if (!resetn) begin
         next_hi_cnt = 4'h0;
      end else if (hi_cnt != 4'hF) begin
         next_hi_cnt = hi_cnt + 4'h1;
      end
   end
   always_ff @(posedge core_clk) begin
      hi_cnt <= next_hi_cnt;
   end
   // A framing character accepted on the input stream.
   assign frame_take = rx_char_valid && rx_char_ready && rx_char_special && rx_char_data == 8'hBC;
   ////////////////////////////////////////////////////////////////////////////////
   a_tx_ref_sel: assert property (tx_clock_from_ref == !tx_clock_select)
      else $error("tx clock source wrong");
   a_rx_ref_sel: assert property (rx_clock_from_ref == elastic_active &&
      elastic_active == (rx_clock_select == spc_pkg::SPC_LVL_LOW &&
      decoder_mode_select != spc_pkg::SPC_LVL_LOW)) else $error("rx clock source wrong");
   // Reset itself is the cause here, so this one is never disabled.
   a_reset_clears: assert property (disable iff (1'b0) !resetn |=>
      driver_enable == 2'h0 && selftest_enable == 2'h3 && !rx_power_enable &&
      !rx_out_valid && !rx_path_settled) else $error("reset did not clear state");
   a_settle_bound: assert property (
      (hi_cnt < 4'hA |-> !rx_path_settled && !rx_char_ready) and
      (hi_cnt == 4'hF |-> rx_path_settled)) else $error("settle timing wrong");
   a_loop_route: assert property (loopback_enable[*4] |->
      cdr_serial_bit == $past(tx_serial_bit)) else $error("loopback not routed");
   a_primary_route: assert property ((!loopback_enable && serial_input_select)[*4]
      |-> cdr_serial_bit == $past(primary_serial_in, 3)) else $error("primary input not routed");
   a_loop_drivers: assert property (loopback_enable[*4] |->
      {secondary_serial_out, primary_serial_out} == $past(driver_enable))
      else $error("loopback drivers not at one");
   a_latch_follow: assert property (out_enable_latch_strobe[*4] |->
      driver_enable == $past(enable_lines, 3)) else $error("open latch not following");
   a_latch_hold: assert property ((!out_enable_latch_strobe)[*4] |->
      $stable(driver_enable)) else $error("closed latch changed");
   a_add_char: assert property (rx_char_added |-> rx_out_valid &&
      rx_out_special && rx_out_data == 8'hBC && elastic_active) else $error("added char wrong");
   a_drop_char: assert property (rx_char_dropped |-> elastic_active &&
      ($past(frame_take) || $past(frame_take, 2))) else $error("drop without framing char");
   c_added: cover property (rx_char_added);
   c_dropped: cover property (rx_char_dropped);
   c_loop: cover property (loopback_enable[*4]);
endmodule

// File: tb/spc_link_model.sv
`timescale 1ns/1ns
// Far transceiver on the two serial inputs: idle holds a mark on the primary and a space
// on the secondary; otherwise the primary changes every cycle and the secondary every second cycle.
module spc_link_model (
   input  wire logic core_clk,
   input  wire logic hold_idle,
   output logic      primary_line,
   output logic      secondary_line
);
   logic [1:0] phase;
   // Lines move off the sampling edge, so the device never sees them change at its edge.
   initial begin
      phase = 2'h0;
      primary_line = 1'b0;
      secondary_line = 1'b0;
   end
   always @(negedge core_clk) begin
      phase <= phase + 2'h1;
      primary_line <= hold_idle | phase[0];
      secondary_line <= ~hold_idle & (phase[1] ^ phase[0]);
   end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ns
// Bench for the serial path control block: scenarios, verdict and hang guard.
module tb_top;
   logic                core_clk, resetn, tx_clock_select, serial_input_select, loopback_enable;
   logic                out_enable_latch_strobe, selftest_latch_strobe, rx_power_latch_strobe;
   logic                primary_serial_in, secondary_serial_in, tx_serial_bit, hold_idle;
   logic                rx_char_valid, rx_char_special, rx_out_ready, rx_char_ready;
   logic                rx_out_valid, rx_out_special, rx_char_added, rx_char_dropped;
   logic                cdr_serial_bit, primary_serial_out, secondary_serial_out;
   logic                tx_clock_from_ref, rx_clock_from_ref, elastic_active, rx_power_enable;
   logic                rx_path_settled;
   logic [1:0]          enable_lines, driver_enable, selftest_enable;
   logic [7:0]          rx_char_data, rx_out_data;
   spc_pkg::spc_level_t rx_clock_select, decoder_mode_select;
   int                  miscompares, checks_done, cyc, n_add, n_drop;
   logic [8:0]          got[$];
   spc_path u_spc_path (.*);
   spc_link_model u_spc_link_model (.core_clk(core_clk), .hold_idle(hold_idle),
      .primary_line(primary_serial_in), .secondary_line(secondary_serial_in));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   // Pulses are counted off the edge so each single-cycle pulse is seen once.
   always @(negedge core_clk) begin
      if (rx_char_added === 1'b1) n_add++;
      if (rx_char_dropped === 1'b1) n_drop++;
   end
   // The whole run needs well under a thousand cycles; this ceiling only catches hangs.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("Checks done %0d, miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(string what, logic [8:0] exp, logic [8:0] seen);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(negedge core_clk);
   endtask
   // Valid is left high for back-to-back sends; the caller lowers it after a batch.
   task automatic push(logic [8:0] c, output bit ok);
      int n;
      n = 0;
      rx_char_valid = 1'b1;
      {rx_char_special, rx_char_data} = c;
      while (rx_char_ready !== 1'b1 && n < 4) begin
         tick(1);
         n++;
      end
      ok = (rx_char_ready === 1'b1);
      tick(1);
   endtask
   task automatic drain(int cnt);
      int w;
      got.delete();
      w = 0;
      rx_out_ready = 1'b1;
      while (got.size() < cnt && w < 100) begin
         if (rx_out_valid === 1'b1) got.push_back({rx_out_special, rx_out_data});
         tick(1);
         w++;
      end
      rx_out_ready = 1'b0;
   endtask
   task automatic compare_got(logic [8:0] exp[$]);
      check("drained_count", 9'(exp.size()), 9'(got.size()));
      foreach (exp[i]) check("rx_out_char", exp[i], got[i]);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic do_reset;
      int n;
      resetn = 1'b0;
      tick(3);
      check("driver_enable", 9'h000, driver_enable);
      check("selftest_enable", 9'h003, selftest_enable);
      check("rx_power_enable", 9'h000, rx_power_enable);
      check("rx_out_valid", 9'h000, rx_out_valid);
      resetn = 1'b1;
      n = 0;
      while (rx_path_settled !== 1'b1 && n < 20) begin
         tick(1);
         n++;
      end
      check("settle_cycles", 9'h00C, 9'(n));
   endtask
   // Receive LOW with the decoder off is never set, as the host must avoid it.
   task automatic t_select;
      for (int i = 1; i < 6; i++) begin
         tx_clock_select = i[0];
         rx_clock_select = spc_pkg::spc_level_t'(i / 3);
         decoder_mode_select = spc_pkg::spc_level_t'(i % 3);
         tick(1);
         check("tx_clock_from_ref", !i[0], tx_clock_from_ref);
         check("elastic_active", i < 3, elastic_active);
         check("rx_clock_from_ref", i < 3, rx_clock_from_ref);
      end
      rx_clock_select = spc_pkg::SPC_LVL_MID;
      decoder_mode_select = spc_pkg::SPC_LVL_MID;
   endtask
   // Far side stalls while the buffer fills to refusal; a framing char arrives near the top.
   task automatic t_fill(bit el);
      bit         ok;
      int         acc;
      logic [8:0] c;
      logic [8:0] exp[$];
      acc = 0;
      n_add = 0;
      n_drop = 0;
      ok = 1'b1;
      rx_clock_select = el ? spc_pkg::SPC_LVL_LOW : spc_pkg::SPC_LVL_MID;
      for (int i = 0; i < 12 && ok; i++) begin
         c = (i == 7) ? 9'h1BC : 9'(i);
         push(c, ok);
         if (ok) acc++;
         if (ok && !(el && i == 7)) exp.push_back(c);
      end
      rx_char_valid = 1'b0;
      check("accepted_fill", 9'h001, acc >= 8);
      drain(exp.size());
      compare_got(exp);
      check("dropped", el, 9'(n_drop));
      check("added", 9'h000, 9'(n_add));
   endtask
   task automatic t_add;
      bit         ok;
      logic [8:0] exp[$];
      n_add = 0;
      rx_clock_select = spc_pkg::SPC_LVL_LOW;
      exp = '{9'h001, 9'h002, 9'h003, 9'h1BC};
      foreach (exp[i]) push(exp[i], ok);
      rx_char_valid = 1'b0;
      exp.push_back(9'h1BC);
      drain(5);
      compare_got(exp);
      tick(2);
      check("added", 9'h001, 9'(n_add));
      rx_clock_select = spc_pkg::SPC_LVL_MID;
   endtask
   task automatic t_latch;
      enable_lines = 2'h1;
      out_enable_latch_strobe = 1'b1;
      tick(4);
      check("driver_enable", 9'h001, driver_enable);
      enable_lines = 2'h2;
      tick(4);
      check("driver_enable", 9'h002, driver_enable);
      out_enable_latch_strobe = 1'b0;
      tick(4);
      enable_lines = 2'h1;
      selftest_latch_strobe = 1'b1;
      rx_power_latch_strobe = 1'b1;
      tick(4);
      check("driver_enable", 9'h002, driver_enable);
      selftest_latch_strobe = 1'b0;
      rx_power_latch_strobe = 1'b0;
      tick(4);
      check("selftest_enable", 9'h001, selftest_enable);
      check("rx_power_enable", 9'h001, rx_power_enable);
   endtask
   // Idle far end: primary carries one, secondary zero; only the secondary driver is on.
   task automatic t_route;
      hold_idle = 1'b1;
      tx_serial_bit = 1'b0;
      for (int i = 0; i < 3; i++) begin
         serial_input_select = (i != 0);
         loopback_enable = i[1];
         tick(4);
         check("cdr_serial_bit", i == 1, cdr_serial_bit);
         check("serial_outs", {i[1], 1'b0},
            {secondary_serial_out, primary_serial_out});
      end
      loopback_enable = 1'b0;
      tx_serial_bit = 1'b1;
      tick(4);
      check("secondary_serial_out", 9'h001, secondary_serial_out);
      hold_idle = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      {resetn, tx_clock_select, serial_input_select, loopback_enable, hold_idle} = 5'h00;
      {out_enable_latch_strobe, selftest_latch_strobe, rx_power_latch_strobe} = 3'h0;
      {tx_serial_bit, rx_char_valid, rx_char_special, rx_out_ready} = 4'h0;
      enable_lines = 2'h0;
      rx_char_data = 8'h00;
      rx_clock_select = spc_pkg::SPC_LVL_MID;
      decoder_mode_select = spc_pkg::SPC_LVL_MID;
      tick(5);
      do_reset();
      t_select();
      t_fill(1'b0);
      t_fill(1'b1);
      t_add();
      t_latch();
      t_route();
      do_reset();
      print_verdict();
   end
endmodule
bind spc_path spc_path_monitor u_spc_path_monitor (.*);
